/* File: ap_map.svh */
// Widths, decode values and timing counts for the host port block.
`ifndef AP_MAP_SVH
`define AP_MAP_SVH

// ----------------------------------------------------------------------------
// Widths and sizes
// ----------------------------------------------------------------------------
`define AP_DATA_W 16
`define AP_FIFO_DEPTH 16

// ----------------------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------------------
`define AP_CLK_NS 40
`define AP_IORDY_MAX_NS 1250
`define AP_IORDY_MAX_CYC (`AP_IORDY_MAX_NS / `AP_CLK_NS)

// ----------------------------------------------------------------------------
// Decode values
// ----------------------------------------------------------------------------
`define AP_DATA_ADDR 3'h0
`define AP_IOCS16_TOP_MODE 3'h2
`define AP_DMARQ_MIN_WORDS 5'h02

`endif

/* File: ap_pkg.sv */
// Types shared by the host port block.
package ap_pkg;

  // --------------------------------------------------------------------------
  // Host control pins, all active low except the address
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic hostReadStrobeN;
    logic hostWriteStrobeN;
    logic commandBlockSelectN;
    logic controlBlockSelectN;
    logic [2:0] registerAddressLines;
    logic dmaGrantInputN;
  } ap_pins_t;

  // Inactive level of the control pins.
  localparam ap_pins_t AP_PINS_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 3'h0, 1'b1};

endpackage

/* File: ap_fifo.sv */
// Flip-flop FIFO with valid and ready on both sides.
`timescale 1ns/10ps
module ap_fifo #(
  parameter int W = 16,
  parameter int DEPTH = 16
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic srst,
  // Filling side.
  input wire logic pushValid,
  input wire logic [W-1:0] pushData,
  output logic pushReady,
  // Draining side.
  output logic popValid,
  output logic [W-1:0] popData,
  input wire logic popReady,
  // Fill level.
  output logic [$clog2(DEPTH+1)-1:0] count
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [CW-1:0] cnt;
  } ap_fifo_t;

  ap_fifo_t st_q;
  ap_fifo_t st_d;
  logic doPush;
  logic doPop;

  // Handshake flags follow the stored fill level.
  assign pushReady = (st_q.cnt != CW'(DEPTH));
  assign popValid = (st_q.cnt != '0);
  assign popData = st_q.mem[st_q.rp];
  assign count = st_q.cnt;
  assign doPush = pushValid & pushReady;
  assign doPop = popReady & popValid;

  // Next state: write at the write pointer, advance pointers, track count.
  always_comb begin
    st_d = st_q;
    if (doPush) begin
      st_d.mem[st_q.wp] = pushData;
      st_d.wp = (st_q.wp == AW'(DEPTH-1)) ? '0 : st_q.wp + 1'b1;
    end
    if (doPop) begin
      st_d.rp = (st_q.rp == AW'(DEPTH-1)) ? '0 : st_q.rp + 1'b1;
    end
    st_d.cnt = st_q.cnt + CW'(doPush) - CW'(doPop);
  end

  // State register.
  always_ff @(posedge mclk) begin
    if (srst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

endmodule

/* File: ap_host_port.sv */
// Device end of the parallel host port: PIO and multiword DMA data path.
//
// Overview of operation
// - Device negates ready early to add waits.
// - Read data valid before ready returns high; at the wait limit ready returns high without data.
// - Ready never held low beyond 1250 ns.
// - 16-bit indication valid only in modes 0-2.
// - DMA read ends with request negated promptly.
// - DMA write ends with request negated promptly.
// - Device accepts any stretched legal host timing.
// - Request raised when device ready to move data.
// - Either side may suspend and resume DMA.
`timescale 1ns/10ps
`include "ap_map.svh"
module ap_host_port #(
  parameter int DATA_W = `AP_DATA_W,
  parameter int FIFO_DEPTH = `AP_FIFO_DEPTH,
  parameter int WAIT_CYC = `AP_IORDY_MAX_CYC
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic srst,
  // Host control pins.
  input wire ap_pkg::ap_pins_t hostPins,
  // Host data lines, split into input, output and active-low enable.
  input wire logic [DATA_W-1:0] hostDataLinesIn,
  output logic [DATA_W-1:0] hostDataLinesOut,
  output logic hostDataLinesOeN,
  // Device status pins toward the host.
  output logic ioReady,
  output logic ioCs16N,
  output logic dmaRequest,
  // Mode settings held by the device firmware.
  input wire logic [2:0] pioMode,
  input wire logic dmaEnable,
  input wire logic dmaDirRead,
  input wire logic readPending,
  // Read data from the device core.
  input wire logic rdValid,
  input wire logic [DATA_W-1:0] rdData,
  output logic rdReady,
  // Write data toward the device core.
  output logic wrValid,
  output logic [DATA_W-1:0] wrData,
  input wire logic wrReady,
  // Wait extension expired without data.
  output logic waitTimeout
);
  import ap_pkg::*;

  localparam int CW = $clog2(FIFO_DEPTH+1);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  typedef struct packed {
    ap_pins_t s1;
    ap_pins_t s2;
    ap_pins_t s3;
    ap_pins_t flt;
    logic [DATA_W-1:0] d1;
    logic [DATA_W-1:0] d2;
    logic [DATA_W-1:0] d3;
    logic [DATA_W-1:0] wrLatch;
    logic [DATA_W-1:0] wrData;
    logic wrValid;
    logic iordy;
    logic [5:0] waitCnt;
    logic timeout;
    logic dmarq;
  } ap_main_t;

  localparam ap_main_t ST_RESET = '{AP_PINS_IDLE, AP_PINS_IDLE, AP_PINS_IDLE, AP_PINS_IDLE,
    '0, '0, '0, '0, '0, 1'b0, 1'b1, 6'h00, 1'b0, 1'b0};

  ap_main_t st_q;
  ap_main_t st_d;
  logic popValid;
  logic [DATA_W-1:0] popData;
  logic popReady;
  logic [CW-1:0] fifoCount;
  logic fltDataPort;
  logic rawDataPort;
  logic readDone;
  logic writeDone;
  logic [5:0] waitMax;
  ap_pins_t fltNext;

  // The wait limit is a whole number of clocks, rounded down so it never exceeds the allowed span.
  assign waitMax = 6'(WAIT_CYC);

  // --------------------------------------------------------------------------
  // Read data buffer
  // --------------------------------------------------------------------------
  // The core fills the buffer; host data-port reads drain it.
  ap_fifo #(
    .W(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .srst(srst),
    .pushValid(rdValid),
    .pushData(rdData),
    .pushReady(rdReady),
    .popValid(popValid),
    .popData(popData),
    .popReady(popReady),
    .count(fifoCount)
  );

  // --------------------------------------------------------------------------
  // Access decode
  // --------------------------------------------------------------------------
  // The data port is the command block at the data address, or any grant cycle.
  assign fltDataPort = !st_q.flt.dmaGrantInputN ||
    (!st_q.flt.commandBlockSelectN && st_q.flt.controlBlockSelectN &&
     st_q.flt.registerAddressLines == `AP_DATA_ADDR);
  assign rawDataPort = !hostPins.dmaGrantInputN ||
    (!hostPins.commandBlockSelectN && hostPins.controlBlockSelectN &&
     hostPins.registerAddressLines == `AP_DATA_ADDR);

  // Filtered pin levels for the next cycle: a bit moves only once stages two and three agree.
  assign fltNext = (st_q.s2 & st_q.s3) | (st_q.flt & (st_q.s2 | st_q.s3));

  // Transfers complete on the trailing strobe edge, so any stretch is tolerated.
  assign readDone = !st_q.flt.hostReadStrobeN && fltNext.hostReadStrobeN && fltDataPort;
  assign writeDone = !st_q.flt.hostWriteStrobeN && fltNext.hostWriteStrobeN && fltDataPort;
  assign popReady = readDone;

  // --------------------------------------------------------------------------
  // Pin side outputs
  // --------------------------------------------------------------------------
  // The head word sits on the bus while a data-port read strobe is low.
  assign hostDataLinesOut = popData;
  assign hostDataLinesOeN = !(!hostPins.hostReadStrobeN && rawDataPort);
  // The 16-bit indication is only offered in the slow PIO modes.
  assign ioCs16N = !(rawDataPort && hostPins.dmaGrantInputN && pioMode <= `AP_IOCS16_TOP_MODE);
  assign ioReady = st_q.iordy;
  assign dmaRequest = st_q.dmarq;
  assign wrValid = st_q.wrValid;
  assign wrData = st_q.wrData;
  assign waitTimeout = st_q.timeout;

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  // Three-stage pin sampling, wait extension, write capture and DMA request.
  always_comb begin
    st_d = st_q;
    st_d.s1 = hostPins;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    // The filtered pins take the agreed value of the second and third stages.
    st_d.flt = fltNext;
    st_d.d1 = hostDataLinesIn;
    st_d.d2 = st_q.d1;
    st_d.d3 = st_q.d2;
    // Keep the last data sample taken while the write strobe was low.
    if (!st_q.flt.hostWriteStrobeN && !st_q.s3.hostWriteStrobeN) begin
      st_d.wrLatch = st_q.d3;
    end
    st_d.wrValid = writeDone;
    if (writeDone) begin
      st_d.wrData = st_q.wrLatch;
    end
    // Ready is pulled low ahead of time when a read would find no data, until waitCnt reaches waitMax.
    st_d.timeout = 1'b0;
    if (readPending && !popValid && st_q.waitCnt < waitMax) begin
      st_d.iordy = 1'b0;
      st_d.waitCnt = st_q.waitCnt + 6'h01;
      st_d.timeout = (st_q.waitCnt == waitMax - 6'h01);
    end else begin
      st_d.iordy = 1'b1;
      if (popValid || !readPending) begin
        st_d.waitCnt = 6'h00;
      end
    end
    // For DMA reads the request drops before the last buffered word can be taken; for writes it follows wrReady.
    if (!dmaEnable) begin
      st_d.dmarq = 1'b0;
    end else if (dmaDirRead) begin
      st_d.dmarq = (fifoCount >= CW'(`AP_DMARQ_MIN_WORDS));
    end else begin
      st_d.dmarq = wrReady;
    end
  end

  // State register.
  always_ff @(posedge mclk) begin
    if (srst) begin
      st_q <= ST_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  a_iordy_limit: assert property (@(posedge mclk) disable iff (srst)
    !st_q.iordy |-> st_q.waitCnt <= waitMax)
    else $error("ready held low beyond the limit");

  a_iordy_release: assert property (@(posedge mclk) disable iff (srst)
    (st_q.waitCnt == waitMax && readPending && !popValid) |=> st_q.iordy)
    else $error("ready not released at the limit");

  a_iordy_data: assert property (@(posedge mclk) disable iff (srst)
    $rose(st_q.iordy) && readPending |-> $past(popValid) || $past(st_q.waitCnt) == waitMax)
    else $error("ready rose without read data");

  a_no_wait: assert property (@(posedge mclk) disable iff (srst)
    popValid ##1 popValid |-> st_q.iordy)
    else $error("wait inserted while data present");

  a_iocs16_mode: assert property (@(posedge mclk) disable iff (srst)
    !ioCs16N |-> pioMode <= `AP_IOCS16_TOP_MODE && hostPins.dmaGrantInputN)
    else $error("16-bit indication outside slow modes");

  a_dmarq_idle: assert property (@(posedge mclk) disable iff (srst)
    !dmaEnable |=> !dmaRequest)
    else $error("request while DMA disabled");

  a_dmarq_read: assert property (@(posedge mclk) disable iff (srst)
    dmaEnable && dmaDirRead && fifoCount < CW'(`AP_DMARQ_MIN_WORDS) |=> !dmaRequest)
    else $error("request held with buffer nearly empty");

  a_dmarq_write: assert property (@(posedge mclk) disable iff (srst)
    dmaEnable && !dmaDirRead && !wrReady |=> !dmaRequest)
    else $error("write request held while core stalls");

  a_write_pulse: assert property (@(posedge mclk) disable iff (srst)
    writeDone |=> wrValid ##1 !wrValid)
    else $error("write word not delivered once");

  a_read_pop: assert property (@(posedge mclk) disable iff (srst)
    readDone && popValid |=> fifoCount == $past(fifoCount) - CW'(1) + CW'($past(rdValid && rdReady)))
    else $error("read did not take one word");

endmodule

/* File: ap_host_model.sv */
// Host side model that drives the strobes, selects, grant and data of the port.
`timescale 1ns/10ps
module ap_host_model (
  // Clock.
  input wire logic mclk,
  // Pins and data toward the device.
  output ap_pkg::ap_pins_t pins,
  output logic [15:0] dataDrv,
  // Device answers.
  input wire logic [15:0] dataBus,
  input wire logic ioReady,
  input wire logic ioCs16N
);
  import ap_pkg::*;

  logic cs16Seen;

  // Pins start idle and the released bus shows a pattern.
  initial begin
    pins = AP_PINS_IDLE;
    dataDrv = 16'h5a5a;
    cs16Seen = 1'b1;
  end

  // One PIO or DMA word; every pin change lands on a falling edge.
  task automatic xfer(input bit rd, input bit dma, input logic [2:0] adr, input logic [15:0] wd,
                      input int extra, output logic [15:0] got);
    int n;
    @(negedge mclk);
    pins.registerAddressLines = adr;
    pins.commandBlockSelectN = dma;
    pins.dmaGrantInputN = !dma;
    dataDrv = rd ? ~dataDrv : wd;
    repeat (2) @(negedge mclk);
    if (rd) begin
      pins.hostReadStrobeN = 1'b0;
    end else begin
      pins.hostWriteStrobeN = 1'b0;
    end
    @(negedge mclk);
    cs16Seen = ioCs16N;
    n = 0;
    // The strobe is held for as long as the device holds ready low.
    while (ioReady !== 1'b1 && n < 64) begin
      @(negedge mclk);
      n++;
    end
    repeat (7 + extra) @(negedge mclk);
    got = dataBus;
    pins.hostReadStrobeN = 1'b1;
    pins.hostWriteStrobeN = 1'b1;
    @(negedge mclk);
    pins = AP_PINS_IDLE;
    dataDrv = ~dataDrv;
    repeat (7 + extra) @(negedge mclk);
  endtask
endmodule

/* File: tb_top.sv */
// Testbench for the host port with a host model and a queue model of the core side.
`timescale 1ns/10ps
module tb_top;
  import ap_pkg::*;
  localparam int WAIT = 8;
  logic mclk, srst, oeN, ioReady, ioCs16N, dmaRequest, rdValid, rdReady, wrValid, wrReady, waitTimeout;
  logic dmaEnable, dmaDirRead, readPending, lastReady;
  logic [2:0] pioMode;
  logic [15:0] dataDrv, dataBus, dOut, rdData, wrData, got;
  ap_pins_t pins;
  int err_count = 0, samples_checked = 0, seed = 70, lowRun = 0, n, k;
  bit took;
  logic [15:0] rdQ[$], wrQ[$];

  // The device drives the bus while its enable is low, the host otherwise.
  assign dataBus = (oeN === 1'b0) ? dOut : dataDrv;

  ap_host_port #(.WAIT_CYC(WAIT), .FIFO_DEPTH(16)) ap_host_port_i (.mclk(mclk), .srst(srst), .hostPins(pins),
    .hostDataLinesIn(dataBus), .hostDataLinesOut(dOut), .hostDataLinesOeN(oeN), .ioReady(ioReady),
    .ioCs16N(ioCs16N), .dmaRequest(dmaRequest), .pioMode(pioMode), .dmaEnable(dmaEnable),
    .dmaDirRead(dmaDirRead), .readPending(readPending), .rdValid(rdValid), .rdData(rdData),
    .rdReady(rdReady), .wrValid(wrValid), .wrData(wrData), .wrReady(wrReady), .waitTimeout(waitTimeout));
  ap_host_model host_i (.mclk(mclk), .pins(pins), .dataDrv(dataDrv), .dataBus(dataBus), .ioReady(ioReady),
    .ioCs16N(ioCs16N));

  // Clock of 40 ns.
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // Compares one value and counts it.
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Offers one word to the read buffer; refused words are not queued.
  task automatic push(input logic [15:0] v);
    @(negedge mclk);
    rdValid = 1'b1;
    rdData = v;
    #1 took = rdReady;
    if (took) rdQ.push_back(v);
    @(negedge mclk);
    rdValid = 1'b0;
    rdData = ~v;
  endtask

  // Host read and write words with the model's expectations.
  task automatic hread(input bit dma);
    host_i.xfer(1'b1, dma, 3'h0, 16'h0, {$random(seed)} % 3, got);
    chk("read word", got, rdQ.size() > 0 ? rdQ.pop_front() : ~got);
  endtask
  task automatic hwrite(input bit dma, input logic [2:0] adr);
    logic [15:0] v;
    v = 16'($random(seed));
    if (adr == 3'h0) wrQ.push_back(v);
    host_i.xfer(1'b0, dma, adr, v, {$random(seed)} % 3, got);
  endtask

  // Watches written words, ready low spans and data ahead of ready.
  always @(posedge mclk) begin
    if (!srst && wrValid) chk("write word", wrData, wrQ.size() > 0 ? wrQ.pop_front() : ~wrData);
    lowRun = ioReady ? 0 : lowRun + 1;
    if (lowRun > WAIT + 1) chk("ready low span", 16'(lowRun), 16'(WAIT));
    if (ioReady && !lastReady && !oeN && rdQ.size() > 0) chk("data before ready", dOut, rdQ[0]);
    lastReady = ioReady;
  end

  // Main sequence.
  initial begin
    srst = 1'b1;
    rdValid = 1'b0;
    rdData = 16'h0;
    wrReady = 1'b0;
    pioMode = 3'h0;
    dmaEnable = 1'b0;
    dmaDirRead = 1'b0;
    readPending = 1'b0;
    lastReady = 1'b1;
    repeat (12) @(negedge mclk);
    srst = 1'b0;
    repeat (4) @(negedge mclk);
    chk("ready after reset", 16'(ioReady), 16'h1);
    chk("request after reset", 16'(dmaRequest), 16'h0);
    for (int m = 0; m < 5; m++) begin
      pioMode = m[2:0];
      hwrite(1'b0, 3'h0);
      chk("iocs16", 16'(host_i.cs16Seen), 16'(m > 2));
    end
    pioMode = 3'h0;
    hwrite(1'b0, 3'h3);
    chk("iocs16 other address", 16'(host_i.cs16Seen), 16'h1);
    n = 0;
    do begin
      push(16'($random(seed)));
      n += int'(took);
    end while (took && n < 40);
    chk("buffer depth", 16'(n), 16'h10);
    repeat (16) hread(1'b0);
    readPending = 1'b1;
    fork
      hread(1'b0);
      begin
        repeat (4) @(negedge mclk);
        chk("ready held low", 16'(ioReady), 16'h0);
        push(16'($random(seed)));
      end
    join
    n = 0;
    while (waitTimeout !== 1'b1 && n < 40) begin
      @(negedge mclk);
      n++;
    end
    chk("wait expiry", 16'(n <= WAIT + 2), 16'h1);
    @(negedge mclk);
    chk("ready after expiry", 16'(ioReady), 16'h1);
    readPending = 1'b0;
    dmaEnable = 1'b1;
    dmaDirRead = 1'b1;
    repeat (4) push(16'($random(seed)));
    repeat (3) @(negedge mclk);
    chk("read request", 16'(dmaRequest), 16'h1);
    k = 0;
    while (dmaRequest === 1'b1 && k < 8) begin
      hread(1'b1);
      chk("iocs16 in grant", 16'(host_i.cs16Seen), 16'h1);
      k++;
    end
    chk("read burst words", 16'(k), 16'h3);
    dmaEnable = 1'b0;
    hread(1'b0);
    dmaEnable = 1'b1;
    dmaDirRead = 1'b0;
    wrReady = 1'b1;
    repeat (3) @(negedge mclk);
    chk("write request", 16'(dmaRequest), 16'h1);
    repeat (2) hwrite(1'b1, 3'h0);
    wrReady = 1'b0;
    repeat (3) @(negedge mclk);
    chk("write request off", 16'(dmaRequest), 16'h0);
    repeat (8) @(negedge mclk);
    chk("writes outstanding", 16'(wrQ.size()), 16'h0);
    end_of_test();
  end

  // Cuts a hang short.
  initial begin
    #800000;
    err_count++;
    end_of_test();
  end
endmodule
